// >>> verilog/solenoid_cfg.svh
// constants for the two-channel hysteretic solenoid current regulator
`ifndef SOLENOID_CFG_SVH
`define SOLENOID_CFG_SVH

`define CLK_PERIOD_NS     10
`define SHORT_BLANK_NS    5000
`define LONG_BLANK_NS     15000
`define DITHER_TICK_NS    10000

`define CMD_W             10
`define OFS_W             12
`define BLANK_W           11

`define HYST_C0           6'h11
`define HYST_C1           6'h15
`define HYST_C2           6'h19
`define HYST_C3           6'h1D
`define HYST_C4           6'h21
`define HYST_C5           6'h25
`define HYST_C6           6'h2A
`define HYST_C7           6'h2E

`define OFF_CMD0          12'h000
`define OFF_CMD1          12'h004
`define OFF_CFG           12'h008
`define OFF_DITHER        12'h00C
`define OFF_FAULT         12'h010
`define OFF_LIVE          12'h014
`define OFF_INT_STAT      12'h018
`define OFF_INT_MASK      12'h01C

`define CFG_STRIDE        8
`define CFG_EN_BIT        0
`define CFG_HYST_LSB      1
`define CFG_RATE_LSB      4
`define DITH_AMP_LSB      0
`define DITH_PER_LSB      8
`define DITH_EN_LSB       16

`define CFG_RESET         32'h0000_0000
`define DITHER_RESET      32'h0000_0000
`define MASK_RESET        4'h0

`endif

// >>> verilog/solenoid_pkg.sv
// types shared by the regulator top and its channel core
package solenoid_pkg;
  typedef logic [1:0][9:0] sense_pair_t;

  typedef struct packed {
    logic [9:0] avg_cmd;
    logic [2:0] hyst_code;
    logic [1:0] edge_rate;
    logic       enable;
  } chan_cfg_t;

  typedef struct packed {
    logic        drive;
    logic        shutdown;
    logic [10:0] blank;
  } chan_state_t;

  typedef struct packed {
    logic [1:0][9:0] cmd;
    logic [31:0]     cfg;
    logic [31:0]     dither;
    logic [1:0]      fault;
    logic [3:0]      int_stat;
    logic [3:0]      int_mask;
    logic            pready;
    logic            pslverr;
    logic [31:0]     prdata;
    logic            irq;
    logic [9:0]      dith_pre;
    logic [7:0]      dith_cnt;
    logic            dith_phase;
  } top_state_t;
endpackage : solenoid_pkg

// >>> verilog/reg_channel.sv
// one channel: switch points, hysteretic switching, blanking, thermal cut
`timescale 1ns/1ns
`include "solenoid_cfg.svh"
module reg_channel #(
  parameter int SHORT_BLANK_CYC = `SHORT_BLANK_NS / `CLK_PERIOD_NS,
  parameter int LONG_BLANK_CYC  = `LONG_BLANK_NS / `CLK_PERIOD_NS
) (
  input  wire logic                    pclk,
  input  wire logic                    presetn,
  input  wire solenoid_pkg::chan_cfg_t cfg,
  input  wire logic signed [11:0]      dither_ofs,
  input  wire logic [9:0]              sense_level,
  input  wire logic                    over_trip,
  input  wire logic                    temp_recovered,
  output logic                         driver_output,
  output logic                         hot,
  output logic                         trip_event,
  output logic                         recover_event
);
  import solenoid_pkg::*;

  chan_state_t st;
  chan_state_t next_st;
  logic        [5:0]  hy;
  logic signed [11:0] mid;
  logic signed [11:0] upper;
  logic signed [11:0] lower;
  logic signed [11:0] sense_s;
  logic               want;

  function automatic logic [5:0] hyst_count(input logic [2:0] code);
    case (code)
      3'd0:    hyst_count = `HYST_C0;
      3'd1:    hyst_count = `HYST_C1;
      3'd2:    hyst_count = `HYST_C2;
      3'd3:    hyst_count = `HYST_C3;
      3'd4:    hyst_count = `HYST_C4;
      3'd5:    hyst_count = `HYST_C5;
      3'd6:    hyst_count = `HYST_C6;
      default: hyst_count = `HYST_C7;
    endcase
  endfunction : hyst_count

  always_comb begin
    hy      = hyst_count(cfg.hyst_code);
    mid     = $signed({2'b00, cfg.avg_cmd}) + dither_ofs;
    upper   = mid + $signed({6'b00_0000, hy});
    lower   = mid - $signed({6'b00_0000, hy});
    sense_s = $signed({2'b00, sense_level});
    next_st       = st;
    trip_event    = 1'b0;
    recover_event = 1'b0;
    if (st.blank != '0) begin
      next_st.blank = st.blank - 11'd1;
    end
    if (over_trip && !st.shutdown) begin
      next_st.shutdown = 1'b1;
      trip_event       = 1'b1;
    // restart once cooled by the margin
    end else if (st.shutdown && temp_recovered && !over_trip) begin
      next_st.shutdown = 1'b0;
      recover_event    = 1'b1;
    end
    want = st.drive;
    if (next_st.shutdown || !cfg.enable) begin
      want = 1'b0;
    end else if (st.blank == '0) begin
      // on to upper point, off to lower point
      if (st.drive && sense_s >= upper) begin
        want = 1'b0;
      end else if (!st.drive && sense_s <= lower) begin
        want = 1'b1;
      end
    end
    if (want != st.drive) begin
      next_st.drive = want;
      // short blanking for slow edge rates 0 and 1
      // long blanking for edge rates 2 and 3
      next_st.blank = cfg.edge_rate[1] ? `BLANK_W'(LONG_BLANK_CYC)
                                       : `BLANK_W'(SHORT_BLANK_CYC);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign driver_output = st.drive;
  assign hot           = st.shutdown;

  int blank_short_n;
  assign blank_short_n = SHORT_BLANK_CYC;

  chk_trip_off: assert property (@(posedge pclk) disable iff (!presetn)
    over_trip && !st.shutdown |=> !st.drive && st.shutdown)
    else $error("channel kept driving after overheat trip");
  chk_hold_off: assert property (@(posedge pclk) disable iff (!presetn)
    st.shutdown && !temp_recovered |=> st.shutdown && !st.drive)
    else $error("channel left shutdown before cooling");
  chk_auto_resume: assert property (@(posedge pclk) disable iff (!presetn)
    st.shutdown && temp_recovered && !over_trip |=> !st.shutdown)
    else $error("channel did not resume after cooling");
  chk_switch_off: assert property (@(posedge pclk) disable iff (!presetn)
    st.drive && st.blank == '0 && sense_s >= upper |=> !st.drive)
    else $error("output stayed on above upper point");
  chk_switch_on: assert property (@(posedge pclk) disable iff (!presetn)
    !st.drive && st.blank == '0 && sense_s <= lower && cfg.enable
    && !st.shutdown && !over_trip |=> st.drive)
    else $error("output stayed off below lower point");
  chk_blank_short: assert property (@(posedge pclk) disable iff (!presetn)
    $changed(st.drive) && !cfg.edge_rate[1] |-> st.blank == 
    `BLANK_W'(blank_short_n) ##1 (st.blank == `BLANK_W'(blank_short_n - 1)
    || st.shutdown))
    else $error("short blanking interval wrong");
  chk_blank_ignore: assert property (@(posedge pclk) disable iff (!presetn)
    st.blank != '0 && !over_trip && cfg.enable |=> $stable(st.drive))
    else $error("comparator acted inside blanking");
  chk_hyst_sym: assert property (@(posedge pclk) disable iff (!presetn)
    upper - lower == $signed({5'b0_0000, hy, 1'b0}))
    else $error("switch points not symmetric");
  chk_hyst_code0: assert property (@(posedge pclk) disable iff (!presetn)
    cfg.hyst_code == 3'd0 |-> upper - mid == 12'sd17)
    else $error("code 0 hysteresis offset wrong");
  chk_hyst_code7: assert property (@(posedge pclk) disable iff (!presetn)
    cfg.hyst_code == 3'd7 |-> mid - lower == 12'sd46)
    else $error("code 7 hysteresis offset wrong");
  chk_mid_cmd: assert property (@(posedge pclk) disable iff (!presetn)
    dither_ofs == '0 |-> mid == $signed({2'b00, cfg.avg_cmd}))
    else $error("midpoint differs from command");

  cov_regulate: cover property (@(posedge pclk) disable iff (!presetn)
    $rose(st.drive) ##[1:1000] $fell(st.drive));
  cov_thermal: cover property (@(posedge pclk) disable iff (!presetn)
    $rose(st.shutdown) ##[1:1000] $fell(st.shutdown));
endmodule : reg_channel

// >>> verilog/solenoid_regulator.sv
// two-channel hysteretic solenoid current regulator with apb registers
`timescale 1ns/1ns
`include "solenoid_cfg.svh"
module solenoid_regulator #(
  parameter int SHORT_BLANK_CYC  = `SHORT_BLANK_NS / `CLK_PERIOD_NS,
  parameter int LONG_BLANK_CYC   = `LONG_BLANK_NS / `CLK_PERIOD_NS,
  parameter int DITHER_TICK_CYC  = `DITHER_TICK_NS / `CLK_PERIOD_NS
) (
  input  wire logic                      pclk,
  input  wire logic                      presetn,
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [11:0]               paddr,
  input  wire logic [31:0]               pwdata,
  output logic [31:0]                    prdata,
  output logic                           pready,
  output logic                           pslverr,
  input  wire solenoid_pkg::sense_pair_t sense_level,
  input  wire logic [1:0]                over_trip,
  input  wire logic [1:0]                temp_recovered,
  output logic [1:0]                     driver_output,
  output logic                           irq
);
  import solenoid_pkg::*;

  top_state_t              st;
  top_state_t              next_st;
  chan_cfg_t   [1:0]       ch_cfg;
  logic signed [1:0][11:0] dither_ofs;
  logic        [1:0]       hot;
  logic        [1:0]       trip_event;
  logic        [1:0]       recover_event;
  logic                    access;
  logic                    done;
  logic                    wr_done;
  logic                    rd_fault;
  logic                    mapped;
  logic                    dith_tick;
  logic        [5:0]       dith_amp;
  logic        [7:0]       dith_per;

  // per-channel configuration fields out of the shared register
  function automatic chan_cfg_t decode_cfg(input logic [31:0] cfg,
                                           input logic [9:0]  cmd,
                                           input int          ch);
    logic [7:0] f;
    f = cfg[ch*`CFG_STRIDE +: `CFG_STRIDE];
    decode_cfg.avg_cmd   = cmd;
    decode_cfg.hyst_code = f[`CFG_HYST_LSB +: 3];
    decode_cfg.edge_rate = f[`CFG_RATE_LSB +: 2];
    decode_cfg.enable    = f[`CFG_EN_BIT];
  endfunction : decode_cfg

  function automatic logic is_mapped(input logic [11:0] a);
    case (a)
      `OFF_CMD0, `OFF_CMD1, `OFF_CFG, `OFF_DITHER,
      `OFF_FAULT, `OFF_LIVE, `OFF_INT_STAT, `OFF_INT_MASK:
        is_mapped = 1'b1;
      default:
        is_mapped = 1'b0;
    endcase
  endfunction : is_mapped

  assign dith_amp = st.dither[`DITH_AMP_LSB +: 6];
  assign dith_per = st.dither[`DITH_PER_LSB +: 8];

  for (genvar ch = 0; ch < 2; ch++) begin : g_chan
    always_comb begin
      ch_cfg[ch] = decode_cfg(st.cfg, st.cmd[ch], ch);
      dither_ofs[ch] = '0;
      if (st.dither[`DITH_EN_LSB + ch] && dith_per != '0) begin
        dither_ofs[ch] = st.dith_phase ? $signed({6'b00_0000, dith_amp})
                                       : -$signed({6'b00_0000, dith_amp});
      end
    end

    reg_channel #(
      .SHORT_BLANK_CYC (SHORT_BLANK_CYC),
      .LONG_BLANK_CYC  (LONG_BLANK_CYC)
    ) u_chan (
      .pclk           (pclk),
      .presetn        (presetn),
      .cfg            (ch_cfg[ch]),
      .dither_ofs     (dither_ofs[ch]),
      .sense_level    (sense_level[ch]),
      .over_trip      (over_trip[ch]),
      .temp_recovered (temp_recovered[ch]),
      .driver_output  (driver_output[ch]),
      .hot            (hot[ch]),
      .trip_event     (trip_event[ch]),
      .recover_event  (recover_event[ch])
    );
  end

  // first access cycle computes the answer, second one completes
  assign access    = psel && penable && !st.pready;
  assign done      = psel && penable && st.pready;
  assign mapped    = is_mapped(paddr);
  assign wr_done   = done && pwrite && mapped;
  assign rd_fault  = done && !pwrite && paddr == `OFF_FAULT;
  assign dith_tick = st.dith_pre == 10'(DITHER_TICK_CYC - 1);

  always_comb begin
    next_st = st;
    next_st.pready = access;
    if (access) begin
      next_st.pslverr = !mapped;
      next_st.prdata  = 32'h0000_0000;
      if (!pwrite) begin
        case (paddr)
          `OFF_CMD0:     next_st.prdata = {22'h00_0000, st.cmd[0]};
          `OFF_CMD1:     next_st.prdata = {22'h00_0000, st.cmd[1]};
          `OFF_CFG:      next_st.prdata = st.cfg;
          `OFF_DITHER:   next_st.prdata = st.dither;
          `OFF_FAULT:    next_st.prdata = {30'h0000_0000, st.fault};
          `OFF_LIVE:     next_st.prdata = {28'h000_0000, hot,
                                           driver_output};
          `OFF_INT_STAT: next_st.prdata = {28'h000_0000, st.int_stat};
          `OFF_INT_MASK: next_st.prdata = {28'h000_0000, st.int_mask};
          default:       next_st.prdata = 32'h0000_0000;
        endcase
      end
    end else if (!st.pready) begin
      next_st.pslverr = 1'b0;
    end
    if (wr_done) begin
      case (paddr)
        `OFF_CMD0:     next_st.cmd[0]   = pwdata[`CMD_W-1:0];
        `OFF_CMD1:     next_st.cmd[1]   = pwdata[`CMD_W-1:0];
        `OFF_CFG:      next_st.cfg      = pwdata;
        `OFF_DITHER:   next_st.dither   = pwdata;
        `OFF_INT_MASK: next_st.int_mask = pwdata[3:0];
        default:       next_st.cfg      = st.cfg;
      endcase
    end
    // reading the fault word releases it, a new trip wins
    if (rd_fault) begin
      next_st.fault = 2'b00;
    end
    // trip sets the fault bit of that channel only
    // each fault bit is driven by its own channel
    next_st.fault = next_st.fault | trip_event;
    if (wr_done && paddr == `OFF_INT_STAT) begin
      next_st.int_stat = st.int_stat & ~pwdata[3:0];
    end
    next_st.int_stat = next_st.int_stat | {recover_event, trip_event};
    next_st.irq = |(next_st.int_stat & next_st.int_mask);
    // dither half-period timer in ticks of the prescaler
    next_st.dith_pre = dith_tick ? 10'h000 : st.dith_pre + 10'h001;
    if (dith_per == '0) begin
      next_st.dith_cnt   = 8'h00;
      next_st.dith_phase = 1'b0;
    end else if (dith_tick) begin
      if (st.dith_cnt >= dith_per - 8'h01) begin
        next_st.dith_cnt   = 8'h00;
        next_st.dith_phase = !st.dith_phase;
      end else begin
        next_st.dith_cnt = st.dith_cnt + 8'h01;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st          <= '0;
      st.cfg      <= `CFG_RESET;
      st.dither   <= `DITHER_RESET;
      st.int_mask <= `MASK_RESET;
    end else begin
      st <= next_st;
    end
  end

  assign prdata  = st.prdata;
  assign pready  = st.pready;
  assign pslverr = st.pslverr;
  assign irq     = st.irq;

  chk_fault_set: assert property (@(posedge pclk) disable iff (!presetn)
    trip_event[0] |=> st.fault[0] && st.int_stat[0])
    else $error("thermal fault bit not set on trip");
  chk_fault_latch: assert property (@(posedge pclk) disable iff (!presetn)
    st.fault[1] && !rd_fault |=> st.fault[1])
    else $error("thermal fault cleared without being read");
  chk_fault_clear: assert property (@(posedge pclk) disable iff (!presetn)
    rd_fault && trip_event == 2'b00 |=> st.fault == 2'b00)
    else $error("thermal fault survived its read");
  chk_fault_indep: assert property (@(posedge pclk) disable iff (!presetn)
    trip_event == 2'b01 && !rd_fault |=> st.fault[1] == $past(st.fault[1]))
    else $error("trip on one channel touched the other");
  chk_chan_indep: assert property (@(posedge pclk) disable iff (!presetn)
    over_trip[0] && !hot[0] && !over_trip[1] && !hot[1] |=> !hot[1])
    else $error("other channel shut down");
  chk_apb_answer: assert property (@(posedge pclk) disable iff (!presetn)
    psel && !penable ##1 psel && penable |=> pready ##1 !pready)
    else $error("apb answer not after one wait cycle");
  chk_irq_level: assert property (@(posedge pclk) disable iff (!presetn)
    irq == |(st.int_stat & st.int_mask))
    else $error("interrupt output disagrees with status");
  chk_dither_sym: assert property (@(posedge pclk) disable iff (!presetn)
    st.dither[`DITH_EN_LSB] && dith_per != '0 && $stable(st.dither)
    && $changed(st.dith_phase) |-> dither_ofs[0] == -$past(dither_ofs[0]))
    else $error("dither step not symmetric");

  cov_fault_read: cover property (@(posedge pclk) disable iff (!presetn)
    st.fault[0] ##[1:1000] rd_fault);
  cov_irq: cover property (@(posedge pclk) disable iff (!presetn)
    $rose(irq));
  cov_dither: cover property (@(posedge pclk) disable iff (!presetn)
    $changed(st.dith_phase) && st.dither[`DITH_EN_LSB + 1]);
endmodule : solenoid_regulator

// >>> bench/apb_host.sv
// apb host model issuing register transfers to the regulator
`timescale 1ns/1ns
module apb_host (
  input  wire logic        pclk,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr,
  output logic             psel    = 1'b0,
  output logic             penable = 1'b0,
  output logic             pwrite  = 1'b0,
  output logic [11:0]      paddr   = 12'h000,
  output logic [31:0]      pwdata  = 32'h0000_0000
);
  // one transfer: setup, access held until pready is sampled high or 100 cycles pass
  task automatic xfer(input logic w, input logic [11:0] a,
                      input logic [31:0] d, output logic [31:0] rd,
                      output logic err);
    int n;
    n = 0;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 100);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    // released bus drives the inverted write data, paddr and pwrite keep their values
    pwdata  <= ~d;
  endtask : xfer
endmodule : apb_host

// >>> bench/hysteretic_solenoid_current_regulator_bench.sv
// self-checking bench for the two-channel solenoid regulator
`timescale 1ns/1ns
`include "solenoid_cfg.svh"
`define CHK(nm, ex, got) begin comparisons++; if ((got) !== (ex)) begin \
  n_fail++; $display("CHECK FAILED %s exp %0h got %0h", nm, ex, got); \
  end end
module hysteretic_solenoid_current_regulator_bench;
  import solenoid_pkg::*;
  localparam int HYST [8] = '{17, 21, 25, 29, 33, 37, 42, 46};
  logic        pclk    = 1'b0;
  logic        presetn = 1'b0;
  logic        psel, penable, pwrite, pready, pslverr, irq, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  sense_pair_t sense_level    = '0;
  logic [1:0]  over_trip      = 2'b00;
  logic [1:0]  temp_recovered = 2'b00;
  logic [1:0]  driver_output;
  int          n_fail = 0;
  int          comparisons = 0;
  int          cycles = 0;

  always #5 pclk = ~pclk;

  solenoid_regulator #(.SHORT_BLANK_CYC(5), .LONG_BLANK_CYC(15),
    .DITHER_TICK_CYC(4)) uut (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sense_level(sense_level),
    .over_trip(over_trip), .temp_recovered(temp_recovered),
    .driver_output(driver_output), .irq(irq));

  apb_host host (.pclk(pclk), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata));

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : complete_run

  always @(posedge pclk) begin
    cycles++;
    if (cycles > 40000) begin
      n_fail++;
      complete_run();
    end
  end

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    host.xfer(1'b1, a, d, rd, err);
  endtask : wr

  task automatic rdx(input logic [11:0] a);
    host.xfer(1'b0, a, 32'h0000_0000, rd, err);
  endtask : rdx

  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask : cyc

  task automatic sense(input int ch, input int v);
    @(posedge pclk);
    sense_level[ch] <= 10'(v);
  endtask : sense

  task automatic wait_drive(input int ch, input logic v);
    int n;
    n = 0;
    while (driver_output[ch] !== v && n < 50) begin
      @(posedge pclk);
      n++;
    end
  endtask : wait_drive

  task automatic test_reset_values();
    rdx(`OFF_CFG);
    `CHK("cfg", `CFG_RESET, rd)
    rdx(`OFF_DITHER);
    `CHK("dither", `DITHER_RESET, rd)
    rdx(`OFF_INT_MASK);
    `CHK("mask", 32'(`MASK_RESET), rd)
    rdx(12'h020);
    `CHK("unmapped err", 1'b1, err)
    `CHK("unmapped data", 32'h0000_0000, rd)
    `CHK("drive idle", 2'b00, driver_output)
    $display("test reset_values done");
  endtask : test_reset_values

  task automatic test_switch_points();
    int h;
    wr(`OFF_CMD0, 32'h0000_0064);
    sense(0, 50);
    for (int c = 0; c < 8; c++) begin
      h = HYST[c];
      wr(`OFF_CFG, 32'((c << 1) | 1));
      cyc(10);
      `CHK("on below", 1'b1, driver_output[0])
      sense(0, 100 + h - 1);
      cyc(10);
      `CHK("on under upper", 1'b1, driver_output[0])
      sense(0, 100 + h);
      cyc(3);
      `CHK("off at upper", 1'b0, driver_output[0])
      sense(0, 100 - h + 1);
      cyc(10);
      `CHK("off over lower", 1'b0, driver_output[0])
      sense(0, 100 - h);
      cyc(3);
      `CHK("on at lower", 1'b1, driver_output[0])
      sense(0, 50);
    end
    $display("test switch_points done");
  endtask : test_switch_points

  task automatic test_blanking();
    int b;
    for (int r = 0; r < 4; r++) begin
      b = (r < 2) ? 5 : 15;
      wr(`OFF_CFG, 32'((r << 4) | 1));
      sense(0, 50);
      cyc(20);
      sense(0, 117);
      wait_drive(0, 1'b0);
      sense_level[0] <= 10'd50;
      cyc(b - 2);
      `CHK("blank holds", 1'b0, driver_output[0])
      cyc(6);
      `CHK("blank over", 1'b1, driver_output[0])
    end
    $display("test blanking done");
  endtask : test_blanking

  task automatic test_thermal();
    wr(`OFF_CFG, 32'h0000_0101);
    wr(`OFF_CMD1, 32'h0000_00C8);
    sense(1, 150);
    sense(0, 50);
    cyc(10);
    `CHK("both on", 2'b11, driver_output)
    wr(`OFF_INT_MASK, 32'h0000_0001);
    @(posedge pclk);
    over_trip <= 2'b01;
    cyc(3);
    `CHK("trip off", 2'b10, driver_output)
    `CHK("irq trip", 1'b1, irq)
    @(posedge pclk);
    over_trip <= 2'b00;
    cyc(10);
    `CHK("stay off", 2'b10, driver_output)
    rdx(`OFF_FAULT);
    `CHK("fault latched", 32'h0000_0001, rd)
    rdx(`OFF_FAULT);
    `CHK("fault cleared", 32'h0000_0000, rd)
    wr(`OFF_INT_STAT, 32'h0000_0001);
    cyc(1);
    `CHK("irq cleared", 1'b0, irq)
    @(posedge pclk);
    temp_recovered <= 2'b01;
    cyc(12);
    `CHK("resume", 2'b11, driver_output)
    `CHK("recover masked", 1'b0, irq)
    rdx(`OFF_INT_STAT);
    `CHK("recover stat", 32'h0000_0004, rd)
    wr(`OFF_INT_STAT, 32'h0000_0004);
    rdx(`OFF_INT_STAT);
    `CHK("stat w1c", 32'h0000_0000, rd)
    $display("test thermal done");
  endtask : test_thermal

  task automatic test_dither();
    wr(`OFF_CFG, 32'h0000_0001);
    wr(`OFF_CMD0, 32'h0000_0064);
    sense(0, 50);
    wr(`OFF_DITHER, 32'h0001_FF0A);
    cyc(10);
    `CHK("dither on", 1'b1, driver_output[0])
    sense(0, 107);
    cyc(3);
    `CHK("dither low upper", 1'b0, driver_output[0])
    sense(0, 74);
    cyc(10);
    `CHK("dither over lower", 1'b0, driver_output[0])
    sense(0, 73);
    cyc(3);
    `CHK("dither low lower", 1'b1, driver_output[0])
    cyc(1100);
    sense(0, 126);
    cyc(10);
    `CHK("dither high under", 1'b1, driver_output[0])
    sense(0, 127);
    cyc(3);
    `CHK("dither high upper", 1'b0, driver_output[0])
    wr(`OFF_DITHER, 32'h0000_0000);
    sense(0, 50);
    cyc(10);
    $display("test dither done");
  endtask : test_dither

  initial begin
    cyc(16);
    presetn <= 1'b1;
    test_reset_values();
    test_switch_points();
    test_blanking();
    test_thermal();
    test_dither();
    complete_run();
  end
endmodule : hysteretic_solenoid_current_regulator_bench
